// ===== fie_fault_flag.sv
// One sticky supply fault flag with its paired clear bit
`timescale 1ns/1ns
module fie_fault_flag #(
  parameter int FLAG_BIT = 15,
  parameter int ACK_BIT = 14
) (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_event,
  fie_wr_if.snk wr,
  output logic o_flag
);

  typedef struct packed {
    logic flag;
  } fie_flag_t;

  fie_flag_t state_ff;
  fie_flag_t nxt_state;
  logic clr;

  // ----------------------------------------------------------------------
  // Both bits must be 1 in one write; a lone bit is ignored so a stray
  // write cannot drop a fault. A new event beats the clear.
  // ----------------------------------------------------------------------
  always_comb begin
    clr = wr.wr_sel[fie_pkg::SEL_SUPPLY] & wr.wdata[FLAG_BIT]
          & wr.wdata[ACK_BIT];
    nxt_state.flag = i_event | (state_ff.flag & ~clr);
  end

  // Flags power up clear
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state_ff <= '{flag: 1'b0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_flag = state_ff.flag;

endmodule // fie_fault_flag

// ===== fie_host_model.sv
// Serial bus host model driving the clock and data lines
`timescale 1ns/1ns
module fie_host_model #(
  parameter logic [6:0] DEV_ADDR = fie_pkg::DEV_ADDR_DFLT
) (
  input wire logic i_clk_sys,
  input wire logic i_sda_oe_n,
  output logic o_scl,
  output logic o_sda
);
  logic sda_drv;
  int nack_count;
  // Pulled-up line: low whenever either party pulls it
  assign o_sda = sda_drv & i_sda_oe_n;
  // Idle bus: clock stands high, data released
  initial begin
    o_scl = 1'b1;
    sda_drv = 1'b1;
    nack_count = 0;
  end
  // Ten clocks a phase keeps well clear of the input filter delay
  task automatic hp;
    repeat (10) @(posedge i_clk_sys);
    #1;
  endtask
  // Start or repeated start, clock left low
  task automatic start;
    sda_drv = 1'b1;
    hp;
    o_scl = 1'b1;
    hp;
    sda_drv = 1'b0;
    hp;
    o_scl = 1'b0;
    hp;
  endtask
  task automatic stop;
    sda_drv = 1'b0;
    hp;
    o_scl = 1'b1;
    hp;
    sda_drv = 1'b1;
    hp;
  endtask
  // Data set mid-low, sampled at the end of high
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    hp;
    o_scl = 1'b1;
    hp;
    r = o_sda;
    o_scl = 1'b0;
    hp;
  endtask
  task automatic byte_io(input logic [7:0] b, input logic m_ack,
                         output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
    bit_io(m_ack, a);
  endtask
  // Byte the device must acknowledge
  task automatic wbyte(input logic [7:0] b);
    logic [7:0] r;
    logic a;
    byte_io(b, 1'b1, r, a);
    if (a !== 1'b0) nack_count++;
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [15:0] d);
    start;
    wbyte({DEV_ADDR, 1'b0});
    wbyte(ofs);
    wbyte(d[15:8]);
    wbyte(d[7:0]);
    stop;
  endtask
  // High byte acked by host, low byte ends with a nack
  task automatic rd(input logic [7:0] ofs, output logic [15:0] d);
    logic a;
    start;
    wbyte({DEV_ADDR, 1'b0});
    wbyte(ofs);
    start;
    wbyte({DEV_ADDR, 1'b1});
    byte_io(8'hff, 1'b0, d[15:8], a);
    byte_io(8'hff, 1'b1, d[7:0], a);
    stop;
  endtask
endmodule // fie_host_model

// ===== fie_irq_field.sv
// One two-bit interrupt enable field with set/clear write encoding
`timescale 1ns/1ns
module fie_irq_field #(
  parameter int LSB = 0,
  parameter int SEL = 0,
  parameter bit RST_ON = 1'b1
) (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  fie_wr_if.snk wr,
  output logic o_on
);

  typedef struct packed {
    logic on;
  } fie_fld_t;

  fie_fld_t state_ff;
  fie_fld_t nxt_state;

  // ----------------------------------------------------------------------
  // Decode write code; only 1h and 3h act, so full-word writes are safe
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    if (wr.wr_sel[SEL]) begin
      case (wr.wdata[LSB +: fie_pkg::FIELD_W])
        fie_pkg::EN_WR_OFF: nxt_state.on = 1'b0;
        fie_pkg::EN_WR_ON: nxt_state.on = 1'b1;
        default: nxt_state.on = state_ff.on;
      endcase
    end
  end

  // Reset value comes from the register reset word
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state_ff <= '{on: RST_ON};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_on = state_ff.on;

endmodule // fie_irq_field

// ===== fie_pkg.sv
// Constants, types and register layout of the fault interrupt enable block
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package fie_pkg;

  // --------------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------------
  localparam logic [7:0] OFS_BOOST_EN = 8'h0a;
  localparam logic [7:0] OFS_LED_EN = 8'h0c;
  localparam logic [7:0] OFS_SUPPLY = 8'h0e;
  localparam logic [7:0] REG_STRIDE = 8'h02;
  localparam logic [15:0] RST_BOOST_EN = 16'ha028;
  localparam logic [15:0] RST_LED_EN = 16'h00aa;
  localparam logic [15:0] RST_SUPPLY = 16'h0000;

  // --------------------------------------------------------------------------
  // Enable field encoding
  // --------------------------------------------------------------------------
  localparam logic [1:0] EN_RD_OFF = 2'h0;
  localparam logic [1:0] EN_RD_ON = 2'h2;
  localparam logic [1:0] EN_WR_OFF = 2'h1;
  localparam logic [1:0] EN_WR_ON = 2'h3;
  localparam int FIELD_W = 2;
  localparam int BOOST_LO_BIT = 2;
  localparam int BOOST_N = 7;
  localparam int LED_LO_BIT = 0;
  localparam int LED_N = 4;
  localparam int LED_FAULT_N = 3;
  localparam int GLOBAL_IDX = 3;

  // --------------------------------------------------------------------------
  // Supply fault flag layout
  // --------------------------------------------------------------------------
  localparam int CFG_ERR_FLAG_BIT = 15;
  localparam int CFG_ERR_ACK_BIT = 14;
  localparam int SYNC_FLAG_BIT = 13;
  localparam int SYNC_ACK_BIT = 12;
  localparam int CP_FLAG_BIT = 11;
  localparam int CP_ACK_BIT = 10;
  localparam int SUPPLY_N = 3;

  // --------------------------------------------------------------------------
  // Write strobe selects and serial engine
  // --------------------------------------------------------------------------
  localparam int SEL_BOOST = 0;
  localparam int SEL_LED = 1;
  localparam int SEL_SUPPLY = 2;
  localparam int SEL_W = 3;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [6:0] DEV_ADDR_DFLT = 7'h2c;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_AACK,
    ST_WR,
    ST_WACK,
    ST_RD,
    ST_RACK,
    ST_RNEXT
  } fie_bus_st_t;

endpackage

// ===== fie_props.sv
// Port-level checker for the fault interrupt enable top
`timescale 1ns/1ns
module fie_props (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_scl,
  input wire logic i_sda_i,
  input wire logic o_sda_o,
  input wire logic o_sda_oe_n,
  input wire logic o_irq_o,
  input wire logic o_irq_oe_n,
  input wire logic [fie_pkg::BOOST_N-1:0] i_boost_fault_flags,
  input wire logic [fie_pkg::LED_FAULT_N-1:0] i_led_fault_flags,
  input wire logic [fie_pkg::SUPPLY_N-1:0] i_supply_irq_gates,
  input wire logic i_cfg_check_error,
  input wire logic i_boost_sync_lost,
  input wire logic i_charge_pump_fault,
  input wire logic [fie_pkg::SUPPLY_N-1:0] o_supply_fault_flags
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  // Lines frozen long enough that no clear write can land in between
  sequence bus_quiet;
    ($stable(i_scl) && $stable(i_sda_i)) [*8];
  endsequence
  // No fault source of any kind for a few cycles
  sequence no_cause;
    (!i_boost_fault_flags && !i_led_fault_flags && !o_supply_fault_flags
     && !i_cfg_check_error && !i_boost_sync_lost
     && !i_charge_pump_fault) [*4];
  endsequence
  cfg_set_a: assert property (i_cfg_check_error |-> ##2 o_supply_fault_flags[2])
    else $error("cfg check flag not set");
  sync_set_a: assert property (i_boost_sync_lost |-> ##2 o_supply_fault_flags[1])
    else $error("sync lost flag not set");
  cp_cause_a: assert property ($rose(o_supply_fault_flags[0]) |-> $past(i_charge_pump_fault, 2))
    else $error("charge pump flag without event");
  flag_sticky_a: assert property (bus_quiet ##0 o_supply_fault_flags[2] |=> o_supply_fault_flags[2])
    else $error("flag dropped without clear write");
  irq_quiet_a: assert property (no_cause |=> o_irq_oe_n)
    else $error("interrupt pin low without cause");
  sda_change_a: assert property ($changed(o_sda_oe_n) |-> !$past(i_scl, 2))
    else $error("data line changed while clock high");
  reset_clean_a: assert property ($fell(i_srst) |-> !o_supply_fault_flags && o_sda_oe_n)
    else $error("outputs not clean after reset");
  pins_zero_a: assert property (!o_irq_o && !o_sda_o)
    else $error("open drain value not zero");
endmodule // fie_props

bind fie_top fie_props u_props (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
  .i_scl(i_scl), .i_sda_i(i_sda_i), .o_sda_o(o_sda_o),
  .o_sda_oe_n(o_sda_oe_n), .o_irq_o(o_irq_o), .o_irq_oe_n(o_irq_oe_n),
  .i_boost_fault_flags(i_boost_fault_flags),
  .i_led_fault_flags(i_led_fault_flags),
  .i_supply_irq_gates(i_supply_irq_gates),
  .i_cfg_check_error(i_cfg_check_error),
  .i_boost_sync_lost(i_boost_sync_lost),
  .i_charge_pump_fault(i_charge_pump_fault),
  .o_supply_fault_flags(o_supply_fault_flags));

// ===== fie_tb.sv
// Self-checking bench for the fault interrupt enable top
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  bad_count++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module testbench;
  localparam logic [7:0] BST = fie_pkg::OFS_BOOST_EN;
  localparam logic [7:0] LED = fie_pkg::OFS_LED_EN;
  localparam logic [7:0] SUP = fie_pkg::OFS_SUPPLY;
  logic i_clk_sys, i_srst, scl, sda, sda_oe_n, irq_oe_n;
  logic [6:0] boost_f;
  logic [2:0] led_f, gates, sup_flags;
  logic cfg_ev, sync_ev, cp_ev;
  logic [15:0] rdat;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  fie_top dut (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_scl(scl),
    .i_sda_i(sda), .o_sda_o(), .o_sda_oe_n(sda_oe_n), .o_irq_o(),
    .o_irq_oe_n(irq_oe_n), .i_boost_fault_flags(boost_f),
    .i_led_fault_flags(led_f), .i_supply_irq_gates(gates),
    .i_cfg_check_error(cfg_ev), .i_boost_sync_lost(sync_ev),
    .i_charge_pump_fault(cp_ev), .o_supply_fault_flags(sup_flags));
  fie_host_model host (.i_clk_sys(i_clk_sys), .i_sda_oe_n(sda_oe_n),
    .o_scl(scl), .o_sda(sda));

  // 50 MHz clock and a hang guard well above the expected run
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 90000) begin
      bad_count++;
      finish_test;
    end
  end

  task automatic finish_test;
    if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tick;
    @(posedge i_clk_sys);
    #1;
  endtask
  task automatic rchk(input logic [7:0] ofs, input logic [15:0] exp);
    host.rd(ofs, rdat);
    `CHK(rdat, exp);
  endtask
  // Pin settles two cycles after its cause; four gives margin
  task automatic irq_chk(input logic exp);
    repeat (4) @(posedge i_clk_sys);
    #1;
    `CHK(irq_oe_n, exp);
  endtask

  // Reset values, reserved bits and an unmapped offset
  task automatic t_reset;
    rchk(BST, 16'ha028);
    rchk(LED, 16'h00aa);
    rchk(SUP, 16'h0000);
    rchk(8'h20, 16'h0000);
  endtask
  // All four write codes on the boost fields, codes 1h and 3h on the LED fields; reserved bits stay zero
  task automatic t_codes;
    host.wr(BST, 16'h0000);
    rchk(BST, 16'ha028);
    host.wr(BST, 16'h5555);
    rchk(BST, 16'h0000);
    host.wr(BST, 16'haaaa);
    rchk(BST, 16'h0000);
    host.wr(BST, 16'hffff);
    rchk(BST, 16'haaa8);
    host.wr(LED, 16'h5555);
    rchk(LED, 16'h0000);
    host.wr(LED, 16'hffff);
    rchk(LED, 16'h00aa);
  endtask
  // Each boost and LED fault input gated by its field; global enable checked on boost fault 6
  task automatic t_irq;
    irq_chk(1'b1);
    for (int i = 0; i < 7; i++) begin
      tick;
      boost_f = 7'h01 << i;
      irq_chk(1'b0);
      host.wr(BST, 16'h0004 << (2 * i));
      irq_chk(1'b1);
      host.wr(BST, 16'h000c << (2 * i));
      irq_chk(1'b0);
    end
    host.wr(BST, 16'h4000);
    irq_chk(1'b1);
    host.wr(BST, 16'hc000);
    irq_chk(1'b0);
    host.wr(LED, 16'h0040);
    irq_chk(1'b1);
    host.wr(LED, 16'h00c0);
    tick;
    boost_f = 7'h00;
    for (int i = 0; i < 3; i++) begin
      tick;
      led_f = 3'h1 << i;
      irq_chk(1'b0);
      host.wr(LED, 16'h0001 << (2 * i));
      irq_chk(1'b1);
      host.wr(LED, 16'h0003 << (2 * i));
      irq_chk(1'b0);
    end
    tick;
    led_f = 3'h0;
    irq_chk(1'b1);
  endtask
  // Sticky supply flags, paired clear, lone clear bit ignored
  task automatic t_flags;
    tick;
    cfg_ev = 1'b1;
    tick;
    cfg_ev = 1'b0;
    irq_chk(1'b1);
    `CHK(sup_flags, 3'h4);
    tick;
    gates = 3'h7;
    irq_chk(1'b0);
    rchk(SUP, 16'h8000);
    host.wr(SUP, 16'h4000);
    rchk(SUP, 16'h8000);
    host.wr(SUP, 16'hc000);
    rchk(SUP, 16'h0000);
    irq_chk(1'b1);
    tick;
    sync_ev = 1'b1;
    cp_ev = 1'b1;
    tick;
    sync_ev = 1'b0;
    cp_ev = 1'b0;
    rchk(SUP, 16'h2800);
    host.wr(SUP, 16'h3000);
    rchk(SUP, 16'h0800);
    host.wr(SUP, 16'h0c00);
    rchk(SUP, 16'h0000);
  endtask

  // Mid-run reset drops a set flag and restores the enable words
  task automatic t_rst;
    host.wr(LED, 16'h0055);
    tick;
    cp_ev = 1'b1;
    tick;
    cp_ev = 1'b0;
    repeat (2) tick;
    `CHK(sup_flags, 3'h1);
    i_srst = 1'b1;
    repeat (4) tick;
    i_srst = 1'b0;
    repeat (4) tick;
    rchk(SUP, 16'h0000);
    rchk(LED, 16'h00aa);
    rchk(BST, 16'ha028);
  endtask

  // Main sequence
  initial begin
    i_srst = 1'b1;
    boost_f = 7'h00;
    led_f = 3'h0;
    gates = 3'h0;
    cfg_ev = 1'b0;
    sync_ev = 1'b0;
    cp_ev = 1'b0;
    repeat (4) @(posedge i_clk_sys);
    #1;
    i_srst = 1'b0;
    repeat (4) @(posedge i_clk_sys);
    t_reset;
    t_codes;
    t_irq;
    t_flags;
    t_rst;
    `CHK(host.nack_count, 0);
    finish_test;
  end
endmodule // testbench

// ===== fie_top.sv
// Serial register slave, enable fields, fault flags and interrupt pin
`timescale 1ns/1ns
module fie_top #(
  parameter logic [6:0] DEV_ADDR = fie_pkg::DEV_ADDR_DFLT // arbitrary value
) (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_scl,
  input wire logic i_sda_i,
  output logic o_sda_o,
  output logic o_sda_oe_n,
  output logic o_irq_o,
  output logic o_irq_oe_n,
  input wire logic [fie_pkg::BOOST_N-1:0] i_boost_fault_flags,
  input wire logic [fie_pkg::LED_FAULT_N-1:0] i_led_fault_flags,
  input wire logic [fie_pkg::SUPPLY_N-1:0] i_supply_irq_gates,
  input wire logic i_cfg_check_error,
  input wire logic i_boost_sync_lost,
  input wire logic i_charge_pump_fault,
  output logic [fie_pkg::SUPPLY_N-1:0] o_supply_fault_flags
);

  // --------------------------------------------------------------------------
  // State of the serial engine and pin drivers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] scl_sy;
    logic [2:0] sda_sy;
    logic scl_f;
    logic sda_f;
    fie_pkg::fie_bus_st_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic first;
    logic hi_phase;
    logic [7:0] hi_byte;
    logic [7:0] rd_lo;
    logic [7:0] ptr;
    logic [fie_pkg::SEL_W-1:0] wr_sel;
    logic [15:0] wdata;
    logic sda_o;
    logic sda_oe_n;
    logic irq_o;
    logic irq_oe_n;
    logic [fie_pkg::SUPPLY_N-1:0] flags;
  } fie_top_t;

  fie_top_t state_ff;
  fie_top_t nxt_state;

  fie_wr_if wr ();

  logic [fie_pkg::BOOST_N-1:0] boost_on;
  logic [fie_pkg::LED_N-1:0] led_on;
  logic [fie_pkg::SUPPLY_N-1:0] sup_flag;
  logic [15:0] boost_rd;
  logic [15:0] led_rd;
  logic [15:0] sup_rd;
  logic [15:0] rd_mux;
  logic f_scl;
  logic f_sda;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic any_fault;
  logic [7:0] ld_byte;

  // --------------------------------------------------------------------------
  // Write strobes leave a flop, so every field sees a clean one-cycle pulse
  // --------------------------------------------------------------------------
  assign wr.wr_sel = state_ff.wr_sel;
  assign wr.wdata = state_ff.wdata;

  // --------------------------------------------------------------------------
  // Enable fields
  // --------------------------------------------------------------------------
  // Boost group: index 0 is bits 3-2, index 6 is bits 15-14
  for (genvar gi = 0; gi < fie_pkg::BOOST_N; gi++) begin : g_boost
    localparam int LO = fie_pkg::BOOST_LO_BIT + gi * fie_pkg::FIELD_W;
    fie_irq_field #(
      .LSB(LO),
      .SEL(fie_pkg::SEL_BOOST),
      .RST_ON(fie_pkg::RST_BOOST_EN[LO + 1])
    ) u_fld (
      .i_clk_sys(i_clk_sys),
      .i_srst(i_srst),
      .wr(wr.snk),
      .o_on(boost_on[gi])
    );
  end

  // LED group: index 3 is the global enable in bits 7-6
  for (genvar gj = 0; gj < fie_pkg::LED_N; gj++) begin : g_led
    localparam int LO = fie_pkg::LED_LO_BIT + gj * fie_pkg::FIELD_W;
    fie_irq_field #(
      .LSB(LO),
      .SEL(fie_pkg::SEL_LED),
      .RST_ON(fie_pkg::RST_LED_EN[LO + 1])
    ) u_fld (
      .i_clk_sys(i_clk_sys),
      .i_srst(i_srst),
      .wr(wr.snk),
      .o_on(led_on[gj])
    );
  end

  // --------------------------------------------------------------------------
  // Supply fault flags
  // --------------------------------------------------------------------------
  fie_fault_flag #(
    .FLAG_BIT(fie_pkg::CFG_ERR_FLAG_BIT),
    .ACK_BIT(fie_pkg::CFG_ERR_ACK_BIT)
  ) u_cfg_check_error_flag (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_event(i_cfg_check_error),
    .wr(wr.snk),
    .o_flag(sup_flag[2])
  );

  fie_fault_flag #(
    .FLAG_BIT(fie_pkg::SYNC_FLAG_BIT),
    .ACK_BIT(fie_pkg::SYNC_ACK_BIT)
  ) u_boost_sync_lost_flag (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_event(i_boost_sync_lost),
    .wr(wr.snk),
    .o_flag(sup_flag[1])
  );

  fie_fault_flag #(
    .FLAG_BIT(fie_pkg::CP_FLAG_BIT),
    .ACK_BIT(fie_pkg::CP_ACK_BIT)
  ) u_charge_pump_fault_flag (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_event(i_charge_pump_fault),
    .wr(wr.snk),
    .o_flag(sup_flag[0])
  );

  // --------------------------------------------------------------------------
  // Read images; enables read 2h or 0h, clear bits and reserved read zero
  // --------------------------------------------------------------------------
  always_comb begin
    boost_rd = '0;
    led_rd = '0;
    for (int k = 0; k < fie_pkg::BOOST_N; k++) begin
      boost_rd[fie_pkg::BOOST_LO_BIT + k * fie_pkg::FIELD_W +: 2] =
        boost_on[k] ? fie_pkg::EN_RD_ON : fie_pkg::EN_RD_OFF;
    end
    for (int k = 0; k < fie_pkg::LED_N; k++) begin
      led_rd[fie_pkg::LED_LO_BIT + k * fie_pkg::FIELD_W +: 2] =
        led_on[k] ? fie_pkg::EN_RD_ON : fie_pkg::EN_RD_OFF;
    end
    sup_rd = fie_pkg::RST_SUPPLY;
    sup_rd[fie_pkg::CFG_ERR_FLAG_BIT] = sup_flag[2];
    sup_rd[fie_pkg::SYNC_FLAG_BIT] = sup_flag[1];
    sup_rd[fie_pkg::CP_FLAG_BIT] = sup_flag[0];
  end

  // Unmapped offsets read as zero
  always_comb begin
    case (state_ff.ptr)
      fie_pkg::OFS_BOOST_EN: rd_mux = boost_rd;
      fie_pkg::OFS_LED_EN: rd_mux = led_rd;
      fie_pkg::OFS_SUPPLY: rd_mux = sup_rd;
      default: rd_mux = '0;
    endcase
  end

  // Supply flags gate through the supply enable register held elsewhere
  always_comb begin
    any_fault = |(i_boost_fault_flags & boost_on)
              | |(i_led_fault_flags & led_on[fie_pkg::LED_FAULT_N-1:0])
              | |(sup_flag & i_supply_irq_gates);
  end

  // --------------------------------------------------------------------------
  // Pin filter: a level counts once the second and third stage agree
  // --------------------------------------------------------------------------
  always_comb begin
    f_scl = (state_ff.scl_sy[1] == state_ff.scl_sy[2]) ?
            state_ff.scl_sy[2] : state_ff.scl_f;
    f_sda = (state_ff.sda_sy[1] == state_ff.sda_sy[2]) ?
            state_ff.sda_sy[2] : state_ff.sda_f;
    scl_rise = f_scl & ~state_ff.scl_f;
    scl_fall = ~f_scl & state_ff.scl_f;
    bus_start = state_ff.scl_f & f_scl & state_ff.sda_f & ~f_sda;
    bus_stop = state_ff.scl_f & f_scl & ~state_ff.sda_f & f_sda;
  end

  // --------------------------------------------------------------------------
  // Serial engine: address, register pointer, then high and low data bytes
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    ld_byte = '0;
    nxt_state.scl_sy = {state_ff.scl_sy[1:0], i_scl};
    nxt_state.sda_sy = {state_ff.sda_sy[1:0], i_sda_i};
    nxt_state.scl_f = f_scl;
    nxt_state.sda_f = f_sda;
    nxt_state.wr_sel = '0;
    nxt_state.sda_o = 1'b0;
    nxt_state.irq_o = 1'b0;
    nxt_state.flags = sup_flag;
    // Pin pulls low only while an enabled fault stands and global is on
    nxt_state.irq_oe_n = ~(led_on[fie_pkg::GLOBAL_IDX] & any_fault);
    // Next read byte; the low byte is snapped with the high one so a
    // word never tears between the two bytes
    if (!state_ff.hi_phase) begin
      ld_byte = rd_mux[15:8];
    end else begin
      ld_byte = state_ff.rd_lo;
    end
    if (bus_start) begin
      nxt_state.st = fie_pkg::ST_ADDR;
      nxt_state.bitcnt = '0;
      nxt_state.sda_oe_n = 1'b1;
      nxt_state.first = 1'b1;
      nxt_state.hi_phase = 1'b0;
    end else if (bus_stop) begin
      nxt_state.st = fie_pkg::ST_IDLE;
      nxt_state.sda_oe_n = 1'b1;
    end else begin
      case (state_ff.st)
        fie_pkg::ST_IDLE: begin
          nxt_state.sda_oe_n = 1'b1;
        end
        fie_pkg::ST_ADDR: begin
          if (scl_rise) begin
            nxt_state.shreg = {state_ff.shreg[6:0], f_sda};
            nxt_state.bitcnt = state_ff.bitcnt + 4'h1;
          end else if (scl_fall && state_ff.bitcnt == fie_pkg::BYTE_BITS) begin
            if (state_ff.shreg[7:1] == DEV_ADDR) begin
              nxt_state.sda_oe_n = 1'b0;
              nxt_state.rw = state_ff.shreg[0];
              nxt_state.st = fie_pkg::ST_AACK;
            end else begin
              nxt_state.st = fie_pkg::ST_IDLE;
            end
          end
        end
        fie_pkg::ST_AACK: begin
          if (scl_fall) begin
            nxt_state.bitcnt = '0;
            if (state_ff.rw) begin
              nxt_state.st = fie_pkg::ST_RD;
              nxt_state.sda_oe_n = ld_byte[7];
              nxt_state.shreg = {ld_byte[6:0], 1'b0};
              nxt_state.rd_lo = rd_mux[7:0];
              nxt_state.hi_phase = ~state_ff.hi_phase;
              if (state_ff.hi_phase) begin
                nxt_state.ptr = state_ff.ptr + fie_pkg::REG_STRIDE;
              end
            end else begin
              nxt_state.st = fie_pkg::ST_WR;
              nxt_state.sda_oe_n = 1'b1;
            end
          end
        end
        fie_pkg::ST_WR: begin
          if (scl_rise) begin
            nxt_state.shreg = {state_ff.shreg[6:0], f_sda};
            nxt_state.bitcnt = state_ff.bitcnt + 4'h1;
          end else if (scl_fall && state_ff.bitcnt == fie_pkg::BYTE_BITS) begin
            nxt_state.sda_oe_n = 1'b0;
            nxt_state.st = fie_pkg::ST_WACK;
            if (state_ff.first) begin
              nxt_state.ptr = state_ff.shreg;
              nxt_state.first = 1'b0;
              nxt_state.hi_phase = 1'b0;
            end else if (!state_ff.hi_phase) begin
              nxt_state.hi_byte = state_ff.shreg;
              nxt_state.hi_phase = 1'b1;
            end else begin
              // Word commits on its low byte; unmapped pointers write nothing
              nxt_state.wr_sel[fie_pkg::SEL_BOOST] =
                (state_ff.ptr == fie_pkg::OFS_BOOST_EN);
              nxt_state.wr_sel[fie_pkg::SEL_LED] =
                (state_ff.ptr == fie_pkg::OFS_LED_EN);
              nxt_state.wr_sel[fie_pkg::SEL_SUPPLY] =
                (state_ff.ptr == fie_pkg::OFS_SUPPLY);
              nxt_state.wdata = {state_ff.hi_byte, state_ff.shreg};
              nxt_state.ptr = state_ff.ptr + fie_pkg::REG_STRIDE;
              nxt_state.hi_phase = 1'b0;
            end
          end
        end
        fie_pkg::ST_WACK: begin
          if (scl_fall) begin
            nxt_state.sda_oe_n = 1'b1;
            nxt_state.bitcnt = '0;
            nxt_state.st = fie_pkg::ST_WR;
          end
        end
        fie_pkg::ST_RD: begin
          if (scl_rise) begin
            nxt_state.bitcnt = state_ff.bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (state_ff.bitcnt == fie_pkg::BYTE_BITS) begin
              nxt_state.sda_oe_n = 1'b1;
              nxt_state.st = fie_pkg::ST_RACK;
            end else begin
              // Open drain: a one is sent by releasing the line
              nxt_state.sda_oe_n = state_ff.shreg[7];
              nxt_state.shreg = {state_ff.shreg[6:0], 1'b0};
            end
          end
        end
        fie_pkg::ST_RACK: begin
          if (scl_rise) begin
            // A not-acknowledge ends the read; the host then stops
            nxt_state.st = f_sda ? fie_pkg::ST_IDLE : fie_pkg::ST_RNEXT;
          end
        end
        fie_pkg::ST_RNEXT: begin
          if (scl_fall) begin
            nxt_state.bitcnt = '0;
            nxt_state.st = fie_pkg::ST_RD;
            nxt_state.sda_oe_n = ld_byte[7];
            nxt_state.shreg = {ld_byte[6:0], 1'b0};
            nxt_state.hi_phase = ~state_ff.hi_phase;
            if (!state_ff.hi_phase) begin
              nxt_state.rd_lo = rd_mux[7:0];
            end else begin
              nxt_state.ptr = state_ff.ptr + fie_pkg::REG_STRIDE;
            end
          end
        end
        default: begin
          nxt_state.st = fie_pkg::ST_IDLE;
          nxt_state.sda_oe_n = 1'b1;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // State register; lines idle high so the filter starts released
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state_ff <= '{scl_sy: 3'h7, sda_sy: 3'h7, scl_f: 1'b1, sda_f: 1'b1,
                   st: fie_pkg::ST_IDLE, bitcnt: 4'h0, shreg: 8'h00,
                   rw: 1'b0, first: 1'b0, hi_phase: 1'b0, hi_byte: 8'h00,
                   rd_lo: 8'h00, ptr: 8'h00, wr_sel: 3'h0, wdata: 16'h0000,
                   sda_o: 1'b0, sda_oe_n: 1'b1, irq_o: 1'b0,
                   irq_oe_n: 1'b1, flags: 3'h0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_sda_o = state_ff.sda_o;
  assign o_sda_oe_n = state_ff.sda_oe_n;
  assign o_irq_o = state_ff.irq_o;
  assign o_irq_oe_n = state_ff.irq_oe_n;
  assign o_supply_fault_flags = state_ff.flags;

endmodule // fie_top

// ===== fie_wr_if.sv
// Register write strobes shared between the top and its field modules
`timescale 1ns/1ns
interface fie_wr_if;
  logic [fie_pkg::SEL_W-1:0] wr_sel;
  logic [15:0] wdata;
  modport src (output wr_sel, output wdata);
  modport snk (input wr_sel, input wdata);
endinterface // fie_wr_if
